/* File: rtl/dmaes_dev.sv */
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module dmaes_dev
   import dmaes_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   dmaes_if.dev link,
   input wire logic [1:0] mode_sel,
   input wire logic auto_restart,
   input wire logic int_on_ready,
   input wire logic in_service_latch,
   input wire logic end_of_block,
   input wire logic byte_match,
   output logic [1:0] dev_state,
   output logic [7:0] setup_base,
   output logic [31:0] setup_assoc,
   output logic override_active
);
   dmaes_state_type state_r;
   dmaes_state_type state_nxt;
   logic [DMAES_NUM_ASSOC-1:0] pend_r;
   logic [DMAES_NUM_ASSOC-1:0] pend_nxt;
   logic last_cmd_r;
   logic last_cmd_nxt;
   logic override_r;
   logic override_nxt;
   logic [7:0] base_r;
   logic [7:0] base_nxt;
   logic [7:0] assoc_r [DMAES_NUM_ASSOC];
   logic [7:0] assoc_nxt [DMAES_NUM_ASSOC];
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic ack_prev_r;
   logic ack_prev_nxt;
   logic fetch_ed_r;
   logic fetch_ed_nxt;

   logic master;
   logic wr_take;
   logic rd_take;
   logic is_cmd;
   logic is_setup;
   logic ready_ok;
   logic return_from_interrupt_opcode_seen;
   logic stop_cond;
   logic found;
   logic [7:0] status_byte;

   assign master = (state_r == DMAES_OPERATING) || (state_r == DMAES_SUSPENDED);
   assign wr_take = link.sel && link.wr && !master;
   assign rd_take = link.sel && link.rd && !master;
   assign is_cmd = link.wdata[DMAES_GROUP_BIT] && (link.wdata[1:0] == DMAES_CMD_LOW);
   assign is_setup = !link.wdata[DMAES_GROUP_BIT] &&
                     (link.wdata[1:0] != DMAES_SETUP_NONE);
   assign ready_ok = link.peripheral_ready_line || override_r;
   assign return_from_interrupt_opcode_seen = link.fetch && fetch_ed_r && (link.fetch_byte == DMAES_RETURN_FROM_INTERRUPT_OPCODE_2);
   assign stop_cond = (end_of_block && !auto_restart) || byte_match;
   assign status_byte = {1'b0, override_r, pend_r, state_r};

   // Bus request decodes the operating and suspended states, masked by the in-service latch
   assign link.bus_request_out = master && !in_service_latch;
   assign link.ie_out = link.ie_in && !in_service_latch;
   assign link.rdata = rdata_r;

   assign dev_state = state_r;
   assign setup_base = base_r;
   assign override_active = override_r;

   genvar gi;
   generate
      for (gi = 0; gi < DMAES_NUM_ASSOC; gi++) begin : g_assoc
         assign setup_assoc[gi*8 +: 8] = assoc_r[gi];
      end
   endgenerate

   always_comb begin
      state_nxt = state_r;
      pend_nxt = pend_r;
      last_cmd_nxt = last_cmd_r;
      override_nxt = override_r;
      base_nxt = base_r;
      assoc_nxt = assoc_r;
      rdata_nxt = rdata_r;
      ack_prev_nxt = link.bus_ack_in_chain;
      fetch_ed_nxt = fetch_ed_r;
      found = 1'b0;

      if (link.fetch) begin
         fetch_ed_nxt = (link.fetch_byte == DMAES_RETURN_FROM_INTERRUPT_OPCODE_1);
      end

      if (rd_take) begin
         rdata_nxt = status_byte;
      end

      // Transitions from outside events
      case (state_r)
         DMAES_DISABLED: begin
            state_nxt = DMAES_DISABLED;
         end
         DMAES_INACTIVE: begin
            if (return_from_interrupt_opcode_seen && link.peripheral_ready_line) begin
               state_nxt = DMAES_OPERATING;
            end else if (ready_ok && !int_on_ready && !in_service_latch) begin
               state_nxt = DMAES_OPERATING;
            end else begin
               state_nxt = DMAES_INACTIVE;
            end
         end
         DMAES_OPERATING: begin
            if (stop_cond) begin
               state_nxt = DMAES_INACTIVE;
            end else if ((mode_sel != DMAES_MODE_CONT) && ack_prev_r &&
                         !link.bus_ack_in_chain) begin
               state_nxt = DMAES_INACTIVE;
            end else if ((mode_sel == DMAES_MODE_CONT) && !ready_ok) begin
               state_nxt = DMAES_SUSPENDED;
            end
         end
         DMAES_SUSPENDED: begin
            if (stop_cond) begin
               state_nxt = DMAES_INACTIVE;
            end else if (ready_ok) begin
               state_nxt = DMAES_OPERATING;
            end
         end
         default: begin
            state_nxt = DMAES_DISABLED;
         end
      endcase

      // Port writes (only reachable when disabled or inactive)
      if (wr_take) begin
         if (pend_r != '0) begin
            // Associated bytes land in fixed group order
            for (int i = 0; i < DMAES_NUM_ASSOC; i++) begin
               if (pend_r[i] && !found) begin
                  found = 1'b1;
                  assoc_nxt[i] = link.wdata;
                  pend_nxt[i] = 1'b0;
               end
            end
            last_cmd_nxt = 1'b0;
            state_nxt = DMAES_DISABLED;
         end else if (is_cmd) begin
            last_cmd_nxt = 1'b1;
            case (link.wdata)
               DMAES_CMD_START: begin
                  if (ready_ok && !in_service_latch) begin
                     state_nxt = DMAES_OPERATING;
                  end else begin
                     state_nxt = DMAES_INACTIVE;
                  end
               end
               DMAES_CMD_REARM: begin
                  if (!last_cmd_r) begin
                     state_nxt = DMAES_DISABLED;
                  end else begin
                     state_nxt = state_r;
                  end
               end
               DMAES_CMD_OVERRIDE: begin
                  override_nxt = 1'b1;
                  state_nxt = DMAES_DISABLED;
               end
               DMAES_CMD_RESET: begin
                  override_nxt = 1'b0;
                  pend_nxt = '0;
                  state_nxt = DMAES_DISABLED;
               end
               default: begin
                  state_nxt = DMAES_DISABLED;
               end
            endcase
         end else begin
            last_cmd_nxt = 1'b0;
            state_nxt = DMAES_DISABLED;
            if (is_setup) begin
               base_nxt = link.wdata;
               pend_nxt = link.wdata[DMAES_PTR_LO +: DMAES_NUM_ASSOC];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= DMAES_DISABLED;
         pend_r <= '0;
         last_cmd_r <= 1'b0;
         override_r <= 1'b0;
         base_r <= 8'h00;
         for (int i = 0; i < DMAES_NUM_ASSOC; i++) begin
            assoc_r[i] <= 8'h00;
         end
         rdata_r <= 8'h00;
         ack_prev_r <= 1'b0;
         fetch_ed_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pend_r <= pend_nxt;
         last_cmd_r <= last_cmd_nxt;
         override_r <= override_nxt;
         base_r <= base_nxt;
         assoc_r <= assoc_nxt;
         rdata_r <= rdata_nxt;
         ack_prev_r <= ack_prev_nxt;
         fetch_ed_r <= fetch_ed_nxt;
      end
   end
endmodule

/* File: rtl/dmaes_pkg.sv */
package dmaes_pkg;
   // Control states, Gray coded along disabled-inactive-operating-suspended
   typedef enum logic [1:0] {
      DMAES_DISABLED = 2'b00,
      DMAES_INACTIVE = 2'b01,
      DMAES_OPERATING = 2'b11,
      DMAES_SUSPENDED = 2'b10
   } dmaes_state_type;

   // Transfer modes
   localparam logic [1:0] DMAES_MODE_BYTE = 2'h0;
   localparam logic [1:0] DMAES_MODE_BURST = 2'h1;
   localparam logic [1:0] DMAES_MODE_CONT = 2'h2;

   // Command group bytes
   localparam logic [7:0] DMAES_CMD_START = 8'h87;
   localparam logic [7:0] DMAES_CMD_STOP = 8'h83;
   localparam logic [7:0] DMAES_CMD_REARM = 8'h8b;
   localparam logic [7:0] DMAES_CMD_OVERRIDE = 8'hb3;
   localparam logic [7:0] DMAES_CMD_RESET = 8'hc3;
   localparam logic [1:0] DMAES_CMD_LOW = 2'h3;

   // Base byte fields
   localparam int DMAES_GROUP_BIT = 7;
   localparam int DMAES_PTR_LO = 3;
   localparam int DMAES_NUM_ASSOC = 4;
   localparam logic [1:0] DMAES_SETUP_NONE = 2'h0;

   // Return-from-interrupt opcode bytes
   localparam logic [7:0] DMAES_RETURN_FROM_INTERRUPT_OPCODE_1 = 8'hed;
   localparam logic [7:0] DMAES_RETURN_FROM_INTERRUPT_OPCODE_2 = 8'h4d;

   // Device I/O port location decoded by the host
   localparam logic [7:0] DMAES_DEV_PORT = 8'h71;

   // Host register map (AXI4-Lite byte addresses)
   localparam logic [7:0] DMAES_H_DATA = 8'h00;
   localparam logic [7:0] DMAES_H_CMD = 8'h04;
   localparam logic [7:0] DMAES_H_PORT = 8'h08;
   localparam logic [7:0] DMAES_H_LINES = 8'h0c;
   localparam logic [7:0] DMAES_H_STAT = 8'h10;
   localparam int DMAES_CMD_RD_BIT = 0;
   localparam int DMAES_CMD_FETCH_BIT = 1;
   localparam int DMAES_LN_READY = 0;
   localparam int DMAES_LN_ACK = 1;
   localparam int DMAES_LN_IEI = 2;
   localparam logic [2:0] DMAES_LINES_RST = 3'h6;
   localparam logic [7:0] DMAES_PORT_RST = 8'h71;
   localparam logic [1:0] DMAES_RESP_OKAY = 2'h0;
   localparam logic [1:0] DMAES_RESP_SLVERR = 2'h2;

   // Host port sequencer states
   typedef enum logic [2:0] {
      DMAES_H_IDLE = 3'b000,
      DMAES_H_RD = 3'b001,
      DMAES_H_CAP = 3'b011,
      DMAES_H_WR = 3'b010,
      DMAES_H_F1 = 3'b100,
      DMAES_H_F2 = 3'b101
   } dmaes_hstate_type;
endpackage

/* File: rtl/dmaes_if.sv */
`timescale 1ns/10ps
interface dmaes_if;
   logic [7:0] io_addr;
   logic sel;
   logic wr;
   logic rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic fetch;
   logic [7:0] fetch_byte;
   logic peripheral_ready_line;
   logic bus_ack_in_chain;
   logic ie_in;
   logic ie_out;
   logic bus_request_out;

   modport dev (
      input io_addr, sel, wr, rd, wdata, fetch, fetch_byte,
      input peripheral_ready_line, bus_ack_in_chain, ie_in,
      output rdata, ie_out, bus_request_out
   );
   modport host (
      output io_addr, sel, wr, rd, wdata, fetch, fetch_byte,
      output peripheral_ready_line, bus_ack_in_chain, ie_in,
      input rdata, ie_out, bus_request_out
   );
endinterface

/* File: rtl/dmaes_host.sv */
`timescale 1ns/10ps
module dmaes_host
   import dmaes_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   dmaes_if.host link,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   dmaes_hstate_type hs_r;
   dmaes_hstate_type hs_nxt;
   logic [7:0] data_r, data_nxt;
   logic [7:0] rbyte_r, rbyte_nxt;
   logic [7:0] port_r, port_nxt;
   logic [2:0] lines_r, lines_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wr_go;
   logic [7:0] waddr;
   logic [7:0] raddr;
   logic busy;

   assign busy = (hs_r != DMAES_H_IDLE);
   assign waddr = {s_axi_awaddr[7:2], 2'b00};
   assign raddr = {s_axi_araddr[7:2], 2'b00};
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r && !busy;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = s_axi_arvalid && !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   assign link.io_addr = port_r;
   assign link.wr = (hs_r == DMAES_H_WR);
   assign link.rd = (hs_r == DMAES_H_RD);
   assign link.sel = (port_r == DMAES_DEV_PORT) && (link.wr || link.rd);
   assign link.wdata = data_r;
   assign link.fetch = (hs_r == DMAES_H_F1) || (hs_r == DMAES_H_F2);
   assign link.fetch_byte = (hs_r == DMAES_H_F2) ? DMAES_RETURN_FROM_INTERRUPT_OPCODE_2 : DMAES_RETURN_FROM_INTERRUPT_OPCODE_1;
   assign link.peripheral_ready_line = lines_r[DMAES_LN_READY];
   assign link.bus_ack_in_chain = lines_r[DMAES_LN_ACK];
   assign link.ie_in = lines_r[DMAES_LN_IEI];

   always_comb begin
      hs_nxt = hs_r;
      data_nxt = data_r;
      rbyte_nxt = rbyte_r;
      port_nxt = port_r;
      lines_nxt = lines_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;

      case (hs_r)
         DMAES_H_IDLE: hs_nxt = DMAES_H_IDLE;
         DMAES_H_RD: hs_nxt = DMAES_H_CAP;
         DMAES_H_CAP: begin
            rbyte_nxt = link.rdata;
            hs_nxt = DMAES_H_IDLE;
         end
         DMAES_H_WR: hs_nxt = DMAES_H_IDLE;
         DMAES_H_F1: hs_nxt = DMAES_H_F2;
         DMAES_H_F2: hs_nxt = DMAES_H_IDLE;
         default: hs_nxt = DMAES_H_IDLE;
      endcase

      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_go) begin
         bvalid_nxt = 1'b1;
         bresp_nxt = DMAES_RESP_OKAY;
         case (waddr)
            DMAES_H_DATA: begin
               if (link.bus_request_out) begin
                  bresp_nxt = DMAES_RESP_SLVERR;
               end else if (s_axi_wstrb[0]) begin
                  data_nxt = s_axi_wdata[7:0];
                  hs_nxt = DMAES_H_WR;
               end
            end
            DMAES_H_CMD: begin
               if (s_axi_wstrb[0] && s_axi_wdata[DMAES_CMD_FETCH_BIT]) begin
                  hs_nxt = DMAES_H_F1;
               end else if (s_axi_wstrb[0] && s_axi_wdata[DMAES_CMD_RD_BIT]) begin
                  if (link.bus_request_out) begin
                     bresp_nxt = DMAES_RESP_SLVERR;
                  end else begin
                     hs_nxt = DMAES_H_RD;
                  end
               end
            end
            DMAES_H_PORT: begin
               if (s_axi_wstrb[0]) begin
                  port_nxt = s_axi_wdata[7:0];
               end
            end
            DMAES_H_LINES: begin
               if (s_axi_wstrb[0]) begin
                  lines_nxt = s_axi_wdata[2:0];
               end
            end
            DMAES_H_STAT: bresp_nxt = DMAES_RESP_OKAY;
            default: bresp_nxt = DMAES_RESP_SLVERR;
         endcase
      end

      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = DMAES_RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         case (raddr)
            DMAES_H_DATA: rdata_nxt = {24'h000000, rbyte_r};
            DMAES_H_CMD: rdata_nxt = 32'h0000_0000;
            DMAES_H_PORT: rdata_nxt = {24'h000000, port_r};
            DMAES_H_LINES: rdata_nxt = {29'h00000000, lines_r};
            DMAES_H_STAT: rdata_nxt = {29'h00000000, link.ie_out,
                                       link.bus_request_out, busy};
            default: rresp_nxt = DMAES_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_r <= DMAES_H_IDLE;
         data_r <= 8'h00;
         rbyte_r <= 8'h00;
         port_r <= DMAES_PORT_RST;
         lines_r <= DMAES_LINES_RST;
         bvalid_r <= 1'b0;
         bresp_r <= DMAES_RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= DMAES_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else begin
         hs_r <= hs_nxt;
         data_r <= data_nxt;
         rbyte_r <= rbyte_nxt;
         port_r <= port_nxt;
         lines_r <= lines_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end
endmodule

/* File: sim/dmaes_chk.sv */
`timescale 1ns/10ps
module dmaes_chk
   import dmaes_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] io_addr,
   input wire logic sel,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic fetch,
   input wire logic [7:0] fetch_byte,
   input wire logic peripheral_ready_line,
   input wire logic bus_ack_in_chain,
   input wire logic ie_in,
   input wire logic ie_out,
   input wire logic bus_request_out,
   input wire logic int_on_ready
);
   logic [2:0] pend_r;
   logic [2:0] pend_nxt;
   logic en_r;
   logic en_nxt;
   logic ovr_r;
   logic ovr_nxt;
   logic take;
   logic cmd0;
   assign take = wr && sel && !bus_request_out;
   assign cmd0 = take && pend_r == 3'h0;
   // Shadow of pending bytes, enable and override
   always_comb begin
      pend_nxt = pend_r;
      en_nxt = en_r;
      ovr_nxt = ovr_r;
      if (take) begin
         pend_nxt = (pend_r != 3'h0) ? pend_r - 3'h1 : 3'h0;
         if (cmd0 && !wdata[7] && wdata[1:0] != 2'h0) begin
            pend_nxt = 3'($countones(wdata[6:3]));
         end
         en_nxt = cmd0 && (wdata == DMAES_CMD_START || (wdata == DMAES_CMD_REARM && en_r));
         ovr_nxt = (ovr_r || (cmd0 && wdata == DMAES_CMD_OVERRIDE))
            && !(cmd0 && wdata == DMAES_CMD_RESET);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_r <= 3'h0;
         en_r <= 1'b0;
         ovr_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         en_r <= en_nxt;
         ovr_r <= ovr_nxt;
      end
   end
   default clocking dcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_RST_QUIET: assert property ($rose(aresetn) |-> !bus_request_out && rdata == 8'h00)
      else $error("request or status set after reset");
   AST_OTHER_DISABLES: assert property (
      take && wdata != DMAES_CMD_START && wdata != DMAES_CMD_REARM |=> !bus_request_out [*2])
      else $error("request after disabling byte");
   AST_ASSOC_NOT_CMD: assert property (take && pend_r != 3'h0 |=> !bus_request_out)
      else $error("associated byte acted as command");
   AST_START_RUNS: assert property (cmd0 && wdata == DMAES_CMD_START
      && (peripheral_ready_line || ovr_r) && ie_in && ie_out |=> bus_request_out)
      else $error("start did not operate");
   AST_START_WAITS: assert property (cmd0 && wdata == DMAES_CMD_START
      && !peripheral_ready_line && !ovr_r |=> !bus_request_out)
      else $error("start without ready operated");
   AST_READY_REQ: assert property (
      en_r && $rose(peripheral_ready_line) && ie_out && !int_on_ready
      |-> ##[1:2] bus_request_out)
      else $error("no request within two cycles of ready");
   AST_SERVICE_BLOCKS: assert property (ie_in && !ie_out |-> !bus_request_out)
      else $error("request while in service");
   AST_SELECT_DECODE: assert property (sel == ((wr || rd) && io_addr == DMAES_DEV_PORT))
      else $error("select decode wrong");
   AST_WR_PULSE: assert property (wr |=> !wr)
      else $error("write strobe longer than one cycle");
   AST_FETCH_PAIR: assert property ($rose(fetch) |-> fetch_byte == DMAES_RETURN_FROM_INTERRUPT_OPCODE_1
      ##1 fetch && fetch_byte == DMAES_RETURN_FROM_INTERRUPT_OPCODE_2 ##1 !fetch)
      else $error("return opcode fetch malformed");
   AST_RETURN_RUNS: assert property (fetch && fetch_byte == DMAES_RETURN_FROM_INTERRUPT_OPCODE_2 && en_r
      && peripheral_ready_line && ie_out |=> bus_request_out)
      else $error("return opcode did not operate");
   cover property (en_r && bus_request_out);
   cover property ($rose(fetch));
   cover property (take && pend_r != 3'h0);
endmodule

/* File: sim/dmaes_tb_top.sv */
`timescale 1ns/10ps
module dmaes_tb_top;
   import dmaes_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, override_active;
   logic [1:0] bresp, rresp, dev_state;
   logic [31:0] rdat, setup_assoc;
   logic [1:0] mode_sel = DMAES_MODE_BURST;
   logic auto_restart = 1'b0;
   logic int_on_ready = 1'b0;
   logic in_service = 1'b0;
   logic eob = 1'b0;
   logic match = 1'b0;
   logic [7:0] setup_base;
   logic [3:0] hs;
   logic [7:0] cmds [3] = '{DMAES_CMD_STOP, DMAES_CMD_RESET, 8'h00};
   int fail_count = 0;
   int total_checks = 0;
   dmaes_if i_link();
   assign hs = {rvalid, arready, bvalid, awready};
   always #12.5 aclk = ~aclk;
   dmaes_dev i_dmaes_dev (.aclk(aclk), .aresetn(aresetn), .link(i_link.dev),
      .mode_sel(mode_sel), .auto_restart(auto_restart), .int_on_ready(int_on_ready),
      .in_service_latch(in_service), .end_of_block(eob), .byte_match(match),
      .dev_state(dev_state), .setup_base(setup_base), .setup_assoc(setup_assoc),
      .override_active(override_active));
   dmaes_host i_dmaes_host (.aclk(aclk), .aresetn(aresetn), .link(i_link.host),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdat), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
   dmaes_chk i_dmaes_chk (.aclk(aclk), .aresetn(aresetn), .io_addr(i_link.io_addr),
      .sel(i_link.sel), .wr(i_link.wr), .rd(i_link.rd), .wdata(i_link.wdata),
      .rdata(i_link.rdata), .fetch(i_link.fetch), .fetch_byte(i_link.fetch_byte),
      .peripheral_ready_line(i_link.peripheral_ready_line),
      .bus_ack_in_chain(i_link.bus_ack_in_chain), .ie_in(i_link.ie_in),
      .ie_out(i_link.ie_out), .bus_request_out(i_link.bus_request_out),
      .int_on_ready(int_on_ready));

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Bounded wait for one handshake bit, at least one edge
   task automatic await(input int b);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n > 40) begin
            fail_count++;
            summarize();
         end
      end while (hs[b] !== 1'b1);
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdat <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      await(0);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      await(1);
      check("bresp", 8'(bresp), 8'(er));
   endtask

   task automatic rreg(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      await(2);
      arvalid <= 1'b0;
      await(3);
      check("rresp", 8'(rresp), 8'(er));
      check("rdata", rdat[7:0], e);
   endtask

   task automatic dwr(input logic [7:0] b);
      wreg(DMAES_H_DATA, {24'h0, b}, DMAES_RESP_OKAY);
   endtask

   task automatic ln(input logic [2:0] v);
      wreg(DMAES_H_LINES, {29'h0, v}, DMAES_RESP_OKAY);
   endtask

   // Port status read, then wait for the host capture
   task automatic status(input logic [7:0] e);
      wreg(DMAES_H_CMD, 32'h1, DMAES_RESP_OKAY);
      repeat (2) @(posedge aclk);
      rreg(DMAES_H_DATA, e, DMAES_RESP_OKAY);
   endtask

   task automatic st(input logic [1:0] e);
      @(posedge aclk);
      check("state", 8'(dev_state), 8'(e));
   endtask

   task automatic req(input logic e);
      check("request", 8'(i_link.bus_request_out), 8'(e));
   endtask

   task automatic evt(input logic m, input logic [1:0] e);
      match <= m;
      eob <= !m;
      @(posedge aclk);
      match <= 1'b0;
      eob <= 1'b0;
      st(e);
   endtask

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   initial begin
      do_reset();
      st(DMAES_DISABLED);
      req(1'b0);
      rreg(DMAES_H_LINES, 8'(DMAES_LINES_RST), DMAES_RESP_OKAY);
      rreg(DMAES_H_PORT, DMAES_DEV_PORT, DMAES_RESP_OKAY);
      rreg(DMAES_H_STAT, 8'h04, DMAES_RESP_OKAY);
      rreg(8'h20, 8'h00, DMAES_RESP_SLVERR);
      wreg(8'h24, 32'h0, DMAES_RESP_SLVERR);
      dwr(8'h51);
      status(8'h28);
      check("base", setup_base, 8'h51);
      dwr(8'haa);
      dwr(8'hbb);
      st(DMAES_DISABLED);
      check("assoc1", setup_assoc[15:8], 8'haa);
      check("assoc3", setup_assoc[31:24], 8'hbb);
      ln(3'h7);
      dwr(8'h09);
      dwr(DMAES_CMD_START);
      st(DMAES_DISABLED);
      check("assoc0", setup_assoc[7:0], DMAES_CMD_START);
      req(1'b0);
      ln(3'h6);
      dwr(DMAES_CMD_START);
      st(DMAES_INACTIVE);
      int_on_ready <= 1'b1;
      ln(3'h7);
      st(DMAES_INACTIVE);
      int_on_ready <= 1'b0;
      @(posedge aclk);
      st(DMAES_OPERATING);
      req(1'b1);
      wreg(DMAES_H_DATA, {24'h0, DMAES_CMD_STOP}, DMAES_RESP_SLVERR);
      wreg(DMAES_H_CMD, 32'h1, DMAES_RESP_SLVERR);
      wreg(DMAES_H_CMD, 32'h2, DMAES_RESP_OKAY);
      st(DMAES_OPERATING);
      ln(3'h6);
      auto_restart <= 1'b1;
      evt(1'b0, DMAES_OPERATING);
      auto_restart <= 1'b0;
      evt(1'b0, DMAES_INACTIVE);
      ln(3'h7);
      st(DMAES_OPERATING);
      evt(1'b1, DMAES_INACTIVE);
      ln(3'h5);
      st(DMAES_INACTIVE);
      mode_sel <= DMAES_MODE_CONT;
      ln(3'h7);
      ln(3'h5);
      st(DMAES_OPERATING);
      ln(3'h4);
      st(DMAES_SUSPENDED);
      req(1'b1);
      ln(3'h7);
      st(DMAES_OPERATING);
      mode_sel <= DMAES_MODE_BURST;
      ln(3'h6);
      evt(1'b1, DMAES_INACTIVE);
      dwr(DMAES_CMD_STOP);
      st(DMAES_DISABLED);
      in_service <= 1'b1;
      ln(3'h7);
      dwr(DMAES_CMD_START);
      st(DMAES_INACTIVE);
      req(1'b0);
      check("ie_out", 8'(i_link.ie_out), 8'h00);
      wreg(DMAES_H_CMD, 32'h2, DMAES_RESP_OKAY);
      @(posedge aclk);
      st(DMAES_OPERATING);
      req(1'b0);
      in_service <= 1'b0;
      @(posedge aclk);
      req(1'b1);
      ln(3'h6);
      evt(1'b1, DMAES_INACTIVE);
      for (int i = 0; i < 3; i++) begin
         dwr(DMAES_CMD_START);
         dwr(DMAES_CMD_REARM);
         st(DMAES_INACTIVE);
         dwr(cmds[i]);
         st(DMAES_DISABLED);
      end
      dwr(DMAES_CMD_OVERRIDE);
      st(DMAES_DISABLED);
      check("override", 8'(override_active), 8'h01);
      dwr(DMAES_CMD_START);
      st(DMAES_OPERATING);
      do_reset();
      st(DMAES_DISABLED);
      check("override", 8'(override_active), 8'h00);
      dwr(8'h79);
      do_reset();
      dwr(DMAES_CMD_START);
      st(DMAES_INACTIVE);
      summarize();
   end
endmodule
